// [design/fxd_datapath.sv]
// fxd_datapath: flag expansion, merge, extended alu, multiplier issue and
// address post-increment for one datapath slice
// assumes: one operation issued per cycle by op_i; results one cycle later
// assumes: every input already lives on clk_i, nothing here synchronises
// assumes: op encodings, field layout and reset values come from fxd_pkg
// Behaviour
// - The expand operator turns single flag bits into byte, halfword or word masks usable as alu operands.
// - Status bits 5 to 3 hold the expansion size, and value 4 selects byte fields from four flags.
// - With status bit 6 set the expander takes its flags from the top end of the flags register.
// - With status bit 6 set each operation using the expand operator rotates the flags left by the flag count.
// - A software write to the flags register beats a rotation in the same cycle and loads all 32 bits.
// - The merge places the foreground field where the flag is 1 and the background field where it is 0.
// - A signed multiply by minus one negates a halfword and may run alongside an add or subtract.
// - A rounded multiply by 0x8000 with shift left one swaps the source halfwords.
// - A rounded multiply by zero gives the source upper halfword shifted right 16 with zero fill.
// - The extended alu applies the configured function code to its A, B and C inputs bit by bit.
// - Post-increment lands at the end of the address stage, so a store of the same register writes the new value.
// - Split multiply happens only in the multiply plus extended alu form with config bit 7 set.
`timescale 1ns/1ps
module fxd_datapath (
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire logic [7:0]           status_reg_i,
  input  wire fxd_pkg::fxd_op_t     op_i,
  input  wire logic [31:0]          opa_i,
  input  wire logic [31:0]          opb_i,
  input  wire logic [31:0]          opc_i,
  input  wire logic                 ealu_c_mask_i,
  input  wire logic                 alu_sub_i,
  input  wire logic [31:0]          mpy_src_i,
  input  wire logic [31:0]          mpy_mul_i,
  input  wire logic                 mpy_signed_i,
  input  wire logic                 mpy_round_i,
  input  wire logic                 mpy_shift_i,
  input  wire logic                 flags_wr_i,
  input  wire logic [31:0]          flags_data_i,
  input  wire logic                 cfg_wr_i,
  input  wire logic [31:0]          cfg_data_i,
  input  wire logic                 areg_wr_i,
  input  wire logic [1:0]           areg_wsel_i,
  input  wire logic [31:0]          areg_wdata_i,
  input  wire logic                 st_req_i,
  input  wire logic [1:0]           st_areg_i,
  input  wire logic [31:0]          st_inc_i,
  input  wire logic                 st_data_is_areg_i,
  input  wire logic [1:0]           st_data_areg_i,
  input  wire logic [31:0]          st_data_i,
  output logic      [31:0]          alu_result_o,
  output logic      [31:0]          mpy_result_o,
  output logic                      result_valid_o,
  output logic      [31:0]          multiple_flags_reg_o,
  output logic      [31:0]          ealu_config_reg_o,
  output logic      [31:0]          expand_mask_o,
  output logic                      st_valid_o,
  output logic      [31:0]          st_addr_o,
  output logic      [31:0]          st_data_o,
  output logic      [127:0]         areg_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  // areg k sits in bits 32k+31 down to 32k of the packed array
  // result and store fields hold until their next writer
  typedef struct packed {
    logic [31:0]      multiple_flags_reg;
    logic [31:0]      ealu_config_reg;
    logic [3:0][31:0] areg;
    logic [31:0]      alu_res;
    logic [31:0]      mpy_res;
    logic [31:0]      mask;
    logic             res_vld;
    logic             st_vld;
    logic [31:0]      st_addr;
    logic [31:0]      st_data;
  } fxd_state_t;

  fxd_state_t s_q;
  fxd_state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // flag expander

  // flags from top end when rotating
  function automatic logic [31:0] fxd_expand(input logic [31:0] mf,
                                             input logic [2:0]  size,
                                             input logic        rot);
    logic [3:0]  sel4;
    logic [1:0]  sel2;
    logic        sel1;
    logic [31:0] m;
    // all sizes are formed and the case picks one, keeping the select flat
    sel4 = rot ? mf[31:28] : mf[3:0];
    sel2 = rot ? mf[31:30] : mf[1:0];
    sel1 = rot ? mf[31] : mf[0];
    m    = {{8{sel4[3]}}, {8{sel4[2]}}, {8{sel4[1]}}, {8{sel4[0]}}};
    case (size)
      fxd_pkg::SIZE_HALF: begin
        m = {{16{sel2[1]}}, {16{sel2[0]}}};
      end
      fxd_pkg::SIZE_WORD: begin
        m = {32{sel1}};
      end
      default: begin
        // spare size codes fall back to byte fields
      end
    endcase
    return m;
  endfunction

  function automatic logic [31:0] fxd_rotate(input logic [31:0] mf,
                                             input logic [2:0]  size);
    logic [31:0] r;
    // count equals the flags that one expansion consumes
    r = {mf[27:0], mf[31:28]};
    case (size)
      fxd_pkg::SIZE_HALF: begin
        r = {mf[29:0], mf[31:30]};
      end
      fxd_pkg::SIZE_WORD: begin
        r = {mf[30:0], mf[31]};
      end
      default: begin
        // spare size codes rotate as byte
      end
    endcase
    return r;
  endfunction

  logic [2:0]  exp_size;
  logic        exp_rot;
  logic [31:0] exp_mask;
  logic        uses_expand;
  logic        rot_now;

  // size and rotate select are levels on the status pins
  assign exp_size = status_reg_i[fxd_pkg::SR_SIZE_LSB +: fxd_pkg::SR_SIZE_W];
  assign exp_rot  = status_reg_i[fxd_pkg::SR_ROT_BIT];

  // mask from flag bits
  // built from the flags as they stand before this cycle's rotation
  assign exp_mask = fxd_expand(s_q.multiple_flags_reg, exp_size, exp_rot);

  // only expand users rotate
  // an alu op that feeds C from opc_i leaves the flags where they are
  assign uses_expand = (op_i == fxd_pkg::OP_MERGE) ||
                       (((op_i == fxd_pkg::OP_EALU) || (op_i == fxd_pkg::OP_MPY_EALU)) && ealu_c_mask_i);
  assign rot_now     = uses_expand && exp_rot;

  ////////////////////////////////////////////////////////////////////////////
  // extended alu, one truth table lookup per bit

  logic [7:0]  ealu_func;
  logic [31:0] ealu_c;
  logic [31:0] ealu_res;

  // config written this cycle only reaches ops from the next cycle on
  assign ealu_func = s_q.ealu_config_reg[fxd_pkg::CFG_FUNC_LSB +: fxd_pkg::CFG_FUNC_W];
  assign ealu_c    = ealu_c_mask_i ? exp_mask : opc_i;

  for (genvar gi = 0; gi < fxd_pkg::DATA_W; gi++) begin : g_ealu
    logic [2:0] idx;
    // A picks the upper half of the table, C the odd entries
    assign idx          = {opa_i[gi], opb_i[gi], ealu_c[gi]};
    assign ealu_res[gi] = ealu_func[idx];
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiplier

  logic        is_mpy;
  logic        split_en;
  logic [31:0] mpy_prod;

  // product is combinational here and lands in the state struct at the edge
  assign is_mpy   = (op_i == fxd_pkg::OP_MPY) || (op_i == fxd_pkg::OP_MPY_EALU) ||
                    (op_i == fxd_pkg::OP_MPY_ADD);
  // split only in mpy plus ealu form
  // a config write in the same cycle as a split op is seen one op late
  assign split_en = (op_i == fxd_pkg::OP_MPY_EALU) && s_q.ealu_config_reg[fxd_pkg::CFG_SPLIT_BIT];

  fxd_mpy u_mpy (
    .src_i    (mpy_src_i),
    .mul_i    (mpy_mul_i),
    .signed_i (mpy_signed_i),
    .round_i  (mpy_round_i),
    .split_i  (split_en),
    .shift_i  (mpy_shift_i),
    .prod_o   (mpy_prod)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic [31:0] st_base;
  logic [31:0] st_next;
  logic        st_self;

  // increment formed in the address stage
  assign st_base = s_q.areg[st_areg_i];
  assign st_next = st_base + st_inc_i;
  // data register equal to address register picks up the new value
  assign st_self = st_data_is_areg_i && (st_data_areg_i == st_areg_i);

  always_comb begin
    // every field holds unless a branch below overwrites it
    s_d         = s_q;

    s_d.res_vld = (op_i != fxd_pkg::OP_NOP);
    s_d.mask    = exp_mask;

    // ops that write no alu result leave it standing
    case (op_i)
      fxd_pkg::OP_MERGE: begin
        s_d.alu_res = (opa_i & exp_mask) | (opb_i & ~exp_mask);
      end
      fxd_pkg::OP_EALU, fxd_pkg::OP_MPY_EALU: begin
        s_d.alu_res = ealu_res;
      end
      fxd_pkg::OP_MPY_ADD: begin
        // add or subtract beside the multiply
        s_d.alu_res = alu_sub_i ? (opa_i - opb_i) : (opa_i + opb_i);
      end
      default: begin
      end
    endcase

    // non-multiply ops leave the last product standing
    if (is_mpy) begin
      s_d.mpy_res = mpy_prod;
    end

    if (rot_now) begin
      s_d.multiple_flags_reg = fxd_rotate(s_q.multiple_flags_reg, exp_size);
    end
    // software write wins, full word
    // the op in this cycle has already used the old flags for its mask
    if (flags_wr_i) begin
      s_d.multiple_flags_reg = flags_data_i;
    end

    if (cfg_wr_i) begin
      s_d.ealu_config_reg = cfg_data_i;
    end

    s_d.st_vld = st_req_i;
    if (st_req_i) begin
      s_d.st_addr = st_base;
      s_d.st_data = st_data_i;
      if (st_data_is_areg_i) begin
        s_d.st_data = st_self ? st_next : s_q.areg[st_data_areg_i];
      end
      s_d.areg[st_areg_i] = st_next;
    end
    // explicit register load beats a post-increment of the same register
    if (areg_wr_i) begin
      s_d.areg[areg_wsel_i] = areg_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  // results are cleared too, so no stale strobe shows after reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q.multiple_flags_reg <= fxd_pkg::MF_RST;
      s_q.ealu_config_reg    <= fxd_pkg::CFG_RST;
      s_q.areg               <= {4{fxd_pkg::AREG_RST}};
      s_q.alu_res            <= 32'h0000_0000;
      s_q.mpy_res            <= 32'h0000_0000;
      s_q.mask               <= 32'h0000_0000;
      s_q.res_vld            <= 1'b0;
      s_q.st_vld             <= 1'b0;
      s_q.st_addr            <= 32'h0000_0000;
      s_q.st_data            <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // every output is a flop, nothing combinational reaches a pin
  assign alu_result_o         = s_q.alu_res;
  assign mpy_result_o         = s_q.mpy_res;
  assign result_valid_o       = s_q.res_vld;
  assign multiple_flags_reg_o = s_q.multiple_flags_reg;
  assign ealu_config_reg_o    = s_q.ealu_config_reg;
  assign expand_mask_o        = s_q.mask;
  assign st_valid_o           = s_q.st_vld;
  assign st_addr_o            = s_q.st_addr;
  assign st_data_o            = s_q.st_data;
  assign areg_o               = s_q.areg;

endmodule

// [design/fxd_pkg.sv]
// fxd_pkg: constants, op codes and field layout for the flag expand datapath
// assumes: single core clock; status and config bits arrive as plain ports
package fxd_pkg;

  localparam int unsigned DATA_W   = 32;
  localparam int unsigned NUM_AREG = 4;
  localparam int unsigned AREG_W   = 2;
  localparam int unsigned SR_W     = 8;

  // status register fields
  localparam int unsigned SR_SIZE_LSB = 3;
  localparam int unsigned SR_SIZE_W   = 3;
  localparam int unsigned SR_ROT_BIT  = 6;

  // expansion size encodings
  localparam logic [2:0] SIZE_BYTE = 3'h4;
  localparam logic [2:0] SIZE_HALF = 3'h5;
  localparam logic [2:0] SIZE_WORD = 3'h6;

  // flag bits consumed per expansion
  localparam int unsigned FLAGS_BYTE = 4;
  localparam int unsigned FLAGS_HALF = 2;
  localparam int unsigned FLAGS_WORD = 1;

  // extended alu configuration layout
  localparam int unsigned CFG_SPLIT_BIT = 7;
  localparam int unsigned CFG_FUNC_LSB  = 8;
  localparam int unsigned CFG_FUNC_W    = 8;

  // reset values
  localparam logic [31:0] MF_RST   = 32'h0000_0000;
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] AREG_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    OP_NOP      = 3'h0,
    OP_MERGE    = 3'h1,
    OP_EALU     = 3'h3,
    OP_MPY      = 3'h2,
    OP_MPY_EALU = 3'h6,
    OP_MPY_ADD  = 3'h7
  } fxd_op_t;

endpackage

// [design/fxd_mpy.sv]
// fxd_mpy: combinational 16x16 multiplier with split and rounded forms
// assumes: caller registers the product and qualifies split_i
`timescale 1ns/1ps
module fxd_mpy (
  input  wire logic [31:0] src_i,
  input  wire logic [31:0] mul_i,
  input  wire logic        signed_i,
  input  wire logic        round_i,
  input  wire logic        split_i,
  input  wire logic        shift_i,
  output logic      [31:0] prod_o
);

  logic signed [15:0] sp_lo;
  logic signed [15:0] sp_hi;
  logic        [15:0] up_lo;
  logic        [15:0] up_hi;
  logic        [31:0] full_u;
  logic        [31:0] full_sh;
  logic signed [31:0] full_s;

  always_comb begin
    sp_lo   = 16'($signed(src_i[7:0])) * 16'($signed(mul_i[7:0]));
    sp_hi   = 16'($signed(src_i[23:16])) * 16'($signed(mul_i[23:16]));
    up_lo   = 16'(src_i[7:0]) * 16'(mul_i[7:0]);
    up_hi   = 16'(src_i[23:16]) * 16'(mul_i[23:16]);
    full_u  = 32'(src_i[15:0]) * 32'(mul_i[15:0]);
    full_s  = 32'($signed(src_i[15:0])) * 32'($signed(mul_i[15:0]));
    full_sh = shift_i ? {full_u[30:0], 1'b0} : full_u;
    prod_o  = 32'h0000_0000;
    if (split_i) begin
      prod_o = signed_i ? {sp_hi, sp_lo} : {up_hi, up_lo};
    end else if (round_i) begin
      prod_o = {full_sh[31:16], src_i[31:16]};
    end else if (signed_i) begin
      // signed product, negate by minus one
      prod_o = full_s;
    end else begin
      prod_o = full_u;
    end
  end

endmodule

// [sim/fxd_datapath_checker.sv]
// fxd_datapath_checker: port-level assertions on the flag expand datapath
// assumes: bound into fxd_datapath, one clock, asynchronous active-low reset
`timescale 1ns/1ps
module fxd_datapath_checker (
  input wire logic             clk_i,
  input wire logic             nrst_i,
  input wire logic [7:0]       status_reg_i,
  input wire fxd_pkg::fxd_op_t op_i,
  input wire logic [31:0]      opa_i,
  input wire logic [31:0]      opb_i,
  input wire logic             flags_wr_i,
  input wire logic [31:0]      flags_data_i,
  input wire logic             areg_wr_i,
  input wire logic             st_req_i,
  input wire logic [1:0]       st_areg_i,
  input wire logic [31:0]      st_inc_i,
  input wire logic             st_data_is_areg_i,
  input wire logic [1:0]       st_data_areg_i,
  input wire logic [31:0]      alu_result_o,
  input wire logic             result_valid_o,
  input wire logic [31:0]      multiple_flags_reg_o,
  input wire logic [31:0]      expand_mask_o,
  input wire logic             st_valid_o,
  input wire logic [31:0]      st_addr_o,
  input wire logic [31:0]      st_data_o
);
  // flags as they stood before the current edge
  logic [31:0] mf_q;
  logic        byte_rot;
  assign byte_rot = op_i == fxd_pkg::OP_MERGE && status_reg_i[6] && status_reg_i[5:3] == fxd_pkg::SIZE_BYTE;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) mf_q <= 32'h0;
    else mf_q <= multiple_flags_reg_o;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////////////
  valid_pulse_a: assert property (op_i != fxd_pkg::OP_NOP |=> result_valid_o)
    else $error("no result strobe after an operation");
  idle_quiet_a: assert property (op_i == fxd_pkg::OP_NOP |=> !result_valid_o)
    else $error("result strobe without an operation");
  flag_write_a: assert property (flags_wr_i |=> multiple_flags_reg_o == $past(flags_data_i))
    else $error("flags write not loaded in full");
  byte_rotate_a: assert property (byte_rot && !flags_wr_i |=> multiple_flags_reg_o == {mf_q[27:0], mf_q[31:28]})
    else $error("flags not rotated left by four");
  no_rotate_a: assert property (!flags_wr_i && !status_reg_i[6] |=> $stable(multiple_flags_reg_o))
    else $error("flags moved with rotate off");
  byte_mask_a: assert property (byte_rot |=> expand_mask_o == {{8{mf_q[31]}}, {8{mf_q[30]}}, {8{mf_q[29]}}, {8{mf_q[28]}}})
    else $error("byte mask not built from top nibble");
  merge_fields_a: assert property (op_i == fxd_pkg::OP_MERGE |=>
    alu_result_o == (($past(opa_i) & expand_mask_o) | ($past(opb_i) & ~expand_mask_o)))
    else $error("merge does not follow the mask");
  store_incr_a: assert property (st_req_i && st_data_is_areg_i && st_data_areg_i == st_areg_i && !areg_wr_i |=>
    st_valid_o && st_data_o == st_addr_o + $past(st_inc_i))
    else $error("store of own address lacks increment");
endmodule

bind fxd_datapath fxd_datapath_checker u_chk (
  .clk_i, .nrst_i, .status_reg_i, .op_i, .opa_i, .opb_i, .flags_wr_i, .flags_data_i, .areg_wr_i, .st_req_i,
  .st_areg_i, .st_inc_i, .st_data_is_areg_i, .st_data_areg_i, .alu_result_o, .result_valid_o,
  .multiple_flags_reg_o, .expand_mask_o, .st_valid_o, .st_addr_o, .st_data_o
);

// [sim/tb.sv]
// tb: self-checking bench for the flag expand datapath
// assumes: fxd_pkg, fxd_datapath and the bound checker are compiled before it
`timescale 1ns/1ps
module tb;
  // ctl: flag write from c, mask on c, sub, signed, round, shift, check mpy, check alu
  typedef struct packed {
    logic [2:0]  op;
    logic [7:0]  st;
    logic [7:0]  ctl;
    logic [31:0] a, b, c, src, mul, ea, em, ef;
  } fxd_row_t;
  localparam logic [31:0] KA    = 32'h88888888;
  localparam logic [31:0] KB    = 32'h33333333;
  localparam logic [31:0] Z     = 32'h00000000;
  localparam int          NROWS = 18;
  localparam fxd_row_t    ROWS [NROWS] = '{
    '{3'h1, 8'h60, 8'h81, KA, KB, 32'h12345678, Z, Z, KB, Z, 32'h12345678},
    '{3'h1, 8'h60, 8'h01, KA, KB, Z, Z, Z, 32'h33333388, Z, 32'h23456781},
    '{3'h1, 8'h60, 8'h01, KA, KB, Z, Z, Z, 32'h33338833, Z, 32'h34567812},
    '{3'h1, 8'h68, 8'h01, KA, KB, Z, Z, Z, KB, Z, 32'hD159E048},
    '{3'h1, 8'h68, 8'h01, KA, KB, Z, Z, Z, KA, Z, 32'h45678123},
    '{3'h1, 8'h70, 8'h01, KA, KB, Z, Z, Z, KB, Z, 32'h8ACF0246},
    '{3'h1, 8'h70, 8'h01, KA, KB, Z, Z, Z, KA, Z, 32'h159E048D},
    '{3'h1, 8'h28, 8'h01, KA, KB, Z, Z, Z, 32'h33338888, Z, 32'h159E048D},
    '{3'h1, 8'h38, 8'h01, KA, KB, Z, Z, Z, 32'h88883388, Z, 32'h159E048D},
    '{3'h3, 8'h60, 8'h41, 32'h0F0F0F0F, 32'h00FF00FF, Z, Z, Z, 32'h0F0F0FFF, Z, 32'h59E048D1},
    '{3'h3, 8'h60, 8'h01, 32'h0F0F0F0F, 32'h00FF00FF, 32'h0000FFFF, Z, Z, 32'h0F0F00FF, Z, 32'h59E048D1},
    '{3'h3, 8'h60, 8'h01, 32'h0000FFFF, 32'h00FF00FF, 32'h0000FFFF, Z, Z, 32'h000000FF, Z, 32'h59E048D1},
    '{3'h7, 8'h60, 8'h33, 32'h00000010, 32'h00000003, Z, 32'h00000005, 32'h0000FFFF, 32'h0000000D, 32'hFFFFFFFB,
      32'h59E048D1},
    '{3'h2, 8'h60, 8'h0E, Z, Z, Z, 32'h12345678, 32'h00008000, Z, 32'h56781234, 32'h59E048D1},
    '{3'h2, 8'h60, 8'h0A, Z, Z, Z, 32'h12345678, Z, Z, 32'h00001234, 32'h59E048D1},
    '{3'h2, 8'h60, 8'h02, Z, Z, Z, 32'h00120034, 32'h00010101, Z, 32'h00003434, 32'h59E048D1},
    '{3'h6, 8'h60, 8'h03, Z, Z, Z, 32'h00120034, 32'h00010101, Z, 32'h00120034, 32'h59E048D1},
    '{3'h6, 8'h60, 8'h13, Z, Z, Z, 32'h00F20084, 32'h00010101, Z, 32'hFFF2FF84, 32'h59E048D1}
  };
  logic             clk_i, nrst_i, ealu_c_mask_i, alu_sub_i, mpy_signed_i, mpy_round_i, mpy_shift_i;
  logic             flags_wr_i, cfg_wr_i, areg_wr_i, st_req_i, st_data_is_areg_i, result_valid_o, st_valid_o;
  logic [1:0]       areg_wsel_i, st_areg_i, st_data_areg_i;
  logic [7:0]       status_reg_i;
  logic [31:0]      opa_i, opb_i, opc_i, mpy_src_i, mpy_mul_i, flags_data_i, cfg_data_i, areg_wdata_i;
  logic [31:0]      st_inc_i, st_data_i, alu_result_o, mpy_result_o, multiple_flags_reg_o;
  logic [31:0]      ealu_config_reg_o, expand_mask_o, st_addr_o, st_data_o;
  logic [127:0]     areg_o;
  fxd_pkg::fxd_op_t op_i;
  int               errors, checked;

  fxd_datapath dut (
    .clk_i, .nrst_i, .status_reg_i, .op_i, .opa_i, .opb_i, .opc_i, .ealu_c_mask_i, .alu_sub_i, .mpy_src_i,
    .mpy_mul_i, .mpy_signed_i, .mpy_round_i, .mpy_shift_i, .flags_wr_i, .flags_data_i, .cfg_wr_i, .cfg_data_i,
    .areg_wr_i, .areg_wsel_i, .areg_wdata_i, .st_req_i, .st_areg_i, .st_inc_i, .st_data_is_areg_i,
    .st_data_areg_i, .st_data_i, .alu_result_o, .mpy_result_o, .result_valid_o, .multiple_flags_reg_o,
    .ealu_config_reg_o, .expand_mask_o, .st_valid_o, .st_addr_o, .st_data_o, .areg_o
  );

  always #12.5 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic results();
    if (errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic drive(input fxd_row_t r);
    op_i <= fxd_pkg::fxd_op_t'(r.op);
    status_reg_i <= r.st;
    {flags_wr_i, ealu_c_mask_i, alu_sub_i, mpy_signed_i, mpy_round_i, mpy_shift_i} <= r.ctl[7:2];
    opa_i <= r.a;
    opb_i <= r.b;
    opc_i <= r.c;
    flags_data_i <= r.c;
    mpy_src_i <= r.src;
    mpy_mul_i <= r.mul;
    cfg_wr_i <= 1'h0;
  endtask

  task automatic check(input fxd_row_t r);
    chk("valid", 1'h1, result_valid_o);
    if (r.ctl[0]) chk("alu", r.ea, alu_result_o);
    if (r.ctl[1]) chk("mpy", r.em, mpy_result_o);
    chk("flags", r.ef, multiple_flags_reg_o);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (500) @(posedge clk_i);
    errors++;
    results();
  end

  initial begin
    clk_i = 1'h0;
    nrst_i = 1'h0;
    op_i = fxd_pkg::OP_NOP;
    {ealu_c_mask_i, alu_sub_i, mpy_signed_i, mpy_round_i, mpy_shift_i, flags_wr_i, cfg_wr_i} = '0;
    {areg_wr_i, st_req_i, st_data_is_areg_i, areg_wsel_i, st_areg_i, st_data_areg_i, status_reg_i} = '0;
    {opa_i, opb_i, opc_i, mpy_src_i, mpy_mul_i, flags_data_i, cfg_data_i, areg_wdata_i, st_inc_i, st_data_i} = '0;
    errors = 0;
    checked = 0;
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'h1;
    @(posedge clk_i);
    cfg_wr_i <= 1'h1;
    cfg_data_i <= 32'h0000D880;
    for (int i = 0; i <= NROWS; i++) begin
      @(posedge clk_i);
      drive(i < NROWS ? ROWS[i] : fxd_row_t'('0));
      @(negedge clk_i);
      if (i > 0) check(ROWS[i-1]);
    end
    @(negedge clk_i);
    chk("idle", 1'h0, result_valid_o);
    chk("config", 32'h0000D880, ealu_config_reg_o);
    // split enable cleared, same operands must give the full product
    @(posedge clk_i);
    cfg_wr_i <= 1'h1;
    cfg_data_i <= 32'h0000D800;
    @(posedge clk_i);
    drive('{3'h6, 8'h60, 8'h02, Z, Z, Z, 32'h00120034, 32'h00010101, Z, Z, Z});
    @(posedge clk_i);
    drive('0);
    @(negedge clk_i);
    chk("unsplit", 32'h00003434, mpy_result_o);
    // back-to-back stores through address register two
    @(posedge clk_i);
    areg_wr_i <= 1'h1;
    areg_wsel_i <= 2'h2;
    areg_wdata_i <= 32'h00000200;
    @(posedge clk_i);
    areg_wr_i <= 1'h0;
    {st_req_i, st_data_is_areg_i, st_areg_i, st_data_areg_i} <= {2'h3, 2'h2, 2'h2};
    st_inc_i <= 32'h00000010;
    @(posedge clk_i);
    st_inc_i <= 32'hFFFFFFFC;
    st_data_is_areg_i <= 1'h0;
    st_data_i <= 32'h00000055;
    @(negedge clk_i);
    chk("store1", {1'h1, 32'h00000200, 32'h00000210, 32'h00000210},
        {st_valid_o, st_addr_o, st_data_o, areg_o[95:64]});
    @(posedge clk_i);
    st_req_i <= 1'h0;
    @(negedge clk_i);
    chk("store2", {1'h1, 32'h00000210, 32'h00000055, 32'h0000020C},
        {st_valid_o, st_addr_o, st_data_o, areg_o[95:64]});
    @(negedge clk_i);
    chk("store end", 1'h0, st_valid_o);
    // reset in mid-run clears every held value
    @(posedge clk_i);
    nrst_i <= 1'h0;
    @(negedge clk_i);
    chk("reset", 128'h0, {multiple_flags_reg_o, ealu_config_reg_o, areg_o[95:64], mpy_result_o});
    // first op on the first edge after release
    @(posedge clk_i);
    nrst_i <= 1'h1;
    drive(ROWS[0]);
    @(posedge clk_i);
    drive('0);
    @(negedge clk_i);
    check(ROWS[0]);
    @(posedge clk_i);
    results();
  end
endmodule
